// file: hw/capture_mode_pkg.sv
// Constants shared by the capture/compare channel
package capture_mode_pkg;
  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [7:0] ADDR_MODE_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_CAPTURE_LOW = 8'h04;
  localparam logic [7:0] ADDR_CAPTURE_HIGH = 8'h08;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h10;
  localparam logic [7:0] ADDR_COMPARE_LOW = 8'h14;
  localparam logic [7:0] ADDR_COMPARE_HIGH = 8'h18;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 3;
  localparam int DUTY_LSB = 4;
  localparam int DUTY_MSB = 5;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'h3F;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;
  // ----------------------------------------
  // Mode encodings
  // ----------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_RSVD_A = 4'h1;
  localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
  localparam logic [3:0] MODE_RSVD_B = 4'h3;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP = 2'b11;
  localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
  localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
endpackage : capture_mode_pkg

// file: hw/edge_prescaler.sv
// Edge prescaler counting qualifying edges of the channel pin
`timescale 1ns/1ps
module edge_prescaler
  import capture_mode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic clear,
  input wire logic edge_seen,
  input wire logic [3:0] last_count,
  output logic fire
);
  logic [3:0] count;
  logic [3:0] next_count;

  always_comb
  begin
    next_count = count;
    fire = 1'b0;
    if (clear)
    begin
      next_count = 4'h0;
    end
    else if (edge_seen)
    begin
      // Count kept on setting change: a lower target can fire early
      if (count >= last_count)
      begin
        next_count = 4'h0;
        fire = 1'b1;
      end
      else
      begin
        next_count = count + 4'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= 4'h0;
    else if (ce)
      count <= next_count;
  end
endmodule : edge_prescaler

// file: hw/capture_mode_control.sv
// Capture/compare channel: mode control, capture path and APB registers
`timescale 1ns/1ps
module capture_mode_control
  import capture_mode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic channel_pin_in,
  input wire logic [15:0] first_timer_count,
  input wire logic adc_enabled,
  output logic channel_out,
  output logic channel_out_drive,
  output logic timer_reset,
  output logic adc_start,
  output logic channel_irq_flag,
  output logic channel_irq,
  output logic pwm_active,
  output logic [9:0] pwm_duty
);
  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [7:0] channel_mode_control;
  logic [15:0] capture_value;
  logic [15:0] compare_value;
  logic channel_irq_enable;
  logic pin_meta;
  logic pin_sync;
  logic pin_prev;
  logic [15:0] timer_sync_a;
  logic [15:0] timer_sync;
  logic match_prev;
  logic [7:0] next_control;
  logic [15:0] next_capture;
  logic [15:0] next_compare;
  logic next_irq_enable;
  logic next_flag;
  logic next_out;
  logic next_drive;
  logic next_timer_reset;
  logic next_adc_start;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  logic next_pwm_active;
  logic [9:0] next_pwm_duty;
  logic next_match_prev;
  logic [3:0] mode;
  logic is_capture;
  logic rise;
  logic fall;
  logic fire4;
  logic cap_event;
  logic match;
  logic match_edge;
  logic wr;
  logic rd_setup;
  logic clear_flag;

  assign mode = channel_mode_control[MODE_MSB:MODE_LSB];
  assign is_capture = (mode[3:2] == 2'b01);
  // Sample the live pin level whatever the pin direction
  assign rise = pin_sync && !pin_prev;
  assign fall = !pin_sync && pin_prev;
  assign match = (timer_sync == compare_value);
  // One event per match, not one per cycle of equality
  assign match_edge = match && !match_prev;
  assign wr = psel && penable && pwrite && pready;
  assign rd_setup = psel && !penable && !pwrite;

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  edge_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clear(!is_capture),
    .edge_seen(rise && mode[1]),
    .last_count(mode[0] ? PRESCALE_16_LAST : PRESCALE_4_LAST),
    .fire(fire4)
  );

  always_comb
  begin
    cap_event = 1'b0;
    unique case (mode)
      MODE_CAP_FALL: cap_event = fall;
      MODE_CAP_RISE: cap_event = rise;
      MODE_CAP_RISE4: cap_event = fire4;
      MODE_CAP_RISE16: cap_event = fire4;
      default: cap_event = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    next_control = channel_mode_control;
    next_capture = capture_value;
    next_compare = compare_value;
    next_irq_enable = channel_irq_enable;
    next_flag = channel_irq_flag;
    next_out = channel_out;
    next_drive = channel_out_drive;
    next_timer_reset = 1'b0;
    next_adc_start = 1'b0;
    clear_flag = 1'b0;
    if (wr)
    begin
      unique case (paddr)
        ADDR_MODE_CONTROL: next_control = pwdata[7:0] & CONTROL_WRITE_MASK;
        ADDR_CAPTURE_LOW: next_capture[7:0] = pwdata[7:0];
        ADDR_CAPTURE_HIGH: next_capture[15:8] = pwdata[7:0];
        ADDR_IRQ_STATUS: clear_flag = pwdata[0];
        ADDR_IRQ_ENABLE: next_irq_enable = pwdata[0];
        ADDR_COMPARE_LOW: next_compare[7:0] = pwdata[7:0];
        ADDR_COMPARE_HIGH: next_compare[15:8] = pwdata[7:0];
        default: ;
      endcase
    end
    if (clear_flag)
      next_flag = 1'b0;
    if (mode == MODE_OFF)
    begin
      next_out = 1'b0;
      next_drive = 1'b0;
    end
    else if (cap_event)
    begin
      // Latest event wins over any unread value
      next_capture = first_timer_count;
      next_flag = 1'b1;
    end
    else if (match_edge)
    begin
      unique case (mode)
        MODE_CMP_TOGGLE:
        begin
          next_out = !channel_out;
          next_drive = 1'b1;
          next_flag = 1'b1;
        end
        MODE_CMP_SET:
        begin
          next_out = 1'b1;
          next_drive = 1'b1;
          next_flag = 1'b1;
        end
        MODE_CMP_CLEAR:
        begin
          next_out = 1'b0;
          next_drive = 1'b1;
          next_flag = 1'b1;
        end
        MODE_CMP_SOFT: next_flag = 1'b1;
        MODE_CMP_SPECIAL:
        begin
          next_flag = 1'b1;
          next_timer_reset = 1'b1;
          next_adc_start = adc_enabled;
        end
        default: ;
      endcase
    end
    if (mode[3:2] != 2'b00 && mode[3:1] != 3'b100 && !(mode[3:2] == MODE_PWM_TOP))
      next_drive = (mode[3:2] == 2'b10) ? 1'b0 : next_drive;
    if (mode[3:2] == 2'b01)
      next_drive = 1'b0;
  end

  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_pready = 1'b0;
    if (psel && !penable)
      next_pready = 1'b1;
    if (rd_setup)
    begin
      unique case (paddr)
        ADDR_MODE_CONTROL: next_prdata = {24'h00_0000, channel_mode_control};
        ADDR_CAPTURE_LOW: next_prdata = {24'h00_0000, capture_value[7:0]};
        ADDR_CAPTURE_HIGH: next_prdata = {24'h00_0000, capture_value[15:8]};
        ADDR_IRQ_STATUS: next_prdata = {31'h0000_0000, channel_irq_flag};
        ADDR_IRQ_ENABLE: next_prdata = {31'h0000_0000, channel_irq_enable};
        ADDR_COMPARE_LOW: next_prdata = {24'h00_0000, compare_value[7:0]};
        ADDR_COMPARE_HIGH: next_prdata = {24'h00_0000, compare_value[15:8]};
        default: next_pslverr = 1'b1;
      endcase
    end
    else if (psel && !penable)
    begin
      unique case (paddr)
        ADDR_MODE_CONTROL, ADDR_CAPTURE_LOW, ADDR_CAPTURE_HIGH, ADDR_IRQ_STATUS,
        ADDR_IRQ_ENABLE, ADDR_COMPARE_LOW, ADDR_COMPARE_HIGH: next_pslverr = 1'b0;
        default: next_pslverr = 1'b1;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_comb
  begin
    next_irq = next_flag && next_irq_enable;
    next_pwm_active = (next_control[3:2] == MODE_PWM_TOP);
    next_pwm_duty = {next_capture[7:0], next_control[DUTY_MSB:DUTY_LSB]};
    // Off mode forgets the last match, so a match still standing at re-entry fires again
    next_match_prev = (mode == MODE_OFF) ? 1'b0 : match;
  end

  // Low ce as in sleep holds every count; work resumes from it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_mode_control <= CONTROL_RESET;
      capture_value <= VALUE_RESET;
      compare_value <= VALUE_RESET;
      channel_irq_enable <= 1'b0;
      channel_irq_flag <= 1'b0;
    end
    else if (ce)
    begin
      channel_mode_control <= next_control;
      capture_value <= next_capture;
      compare_value <= next_compare;
      channel_irq_enable <= next_irq_enable;
      channel_irq_flag <= next_flag;
    end
  end

  // ----------------------------------------
  // Channel, interrupt, event and PWM outputs
  // ----------------------------------------
  // Latch and drive hold their level while ce is low
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_irq <= 1'b0;
      channel_out <= 1'b0;
      channel_out_drive <= 1'b0;
      timer_reset <= 1'b0;
      adc_start <= 1'b0;
      pwm_active <= 1'b0;
      pwm_duty <= 10'h000;
    end
    else if (ce)
    begin
      channel_irq <= next_irq;
      channel_out <= next_out;
      channel_out_drive <= next_drive;
      timer_reset <= next_timer_reset;
      adc_start <= next_adc_start;
      pwm_active <= next_pwm_active;
      pwm_duty <= next_pwm_duty;
    end
  end

  // ----------------------------------------
  // Pin and timer sampling
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
      timer_sync_a <= VALUE_RESET;
      timer_sync <= VALUE_RESET;
      match_prev <= 1'b0;
    end
    else if (ce)
    begin
      // Pin is asynchronous: two stages before any logic reads it
      pin_meta <= channel_pin_in;
      pin_sync <= pin_meta;
      // Tracked in every mode, so a mode change leaves no stale edge to flag
      pin_prev <= pin_sync;
      // Timer shares this clock; stages only pipeline the compare
      timer_sync_a <= first_timer_count;
      timer_sync <= timer_sync_a;
      match_prev <= next_match_prev;
    end
  end

  // ----------------------------------------
  // Bus response
  // ----------------------------------------
  // Answer built at setup, so every access made while ce is high ends in one cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (ce)
    begin
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule : capture_mode_control

// file: verif/capture_mode_control_props.sv
// Port-level checks for the capture channel
`timescale 1ns/1ps
module capture_mode_control_props
  import capture_mode_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_enabled,
  input wire logic timer_reset,
  input wire logic adc_start,
  input wire logic channel_irq_flag
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_ctrl_read;
    psel && penable && pready && !pwrite && paddr == ADDR_MODE_CONTROL;
  endsequence
  a_ready_follows: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ctrl_top_zero: assert property (s_ctrl_read |-> prdata[7:6] == 2'b00)
    else $error("control bits 7-6 not zero");
  a_err_reads_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("error access returned data");
  // A status write may clear it, so only quiet cycles are judged
  a_flag_sticky: assert property (channel_irq_flag && !(psel && pwrite) |=>
    channel_irq_flag) else $error("flag dropped without a write");
  a_adc_gated: assert property (adc_start |-> $past(adc_enabled))
    else $error("conversion started while disabled");
  a_adc_with_reset: assert property (adc_start |-> timer_reset)
    else $error("conversion without timer reset");
  a_reset_single: assert property (timer_reset |=> !timer_reset)
    else $error("timer reset longer than one cycle");
  a_event_flag: assert property (timer_reset |-> ##[0:2] channel_irq_flag)
    else $error("special event without flag");
endmodule : capture_mode_control_props

bind capture_mode_control capture_mode_control_props props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .adc_enabled(adc_enabled), .timer_reset(timer_reset), .adc_start(adc_start),
  .channel_irq_flag(channel_irq_flag)
);

// file: verif/pin_source.sv
// Behavioural source of pulses on the channel pin
`timescale 1ns/1ps
module pin_source (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic [3:0] hold,
  output logic pin
);
  logic [3:0] cnt;
  // Width varies per pulse, so prompt and slow edges both occur
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin <= 1'b0;
      cnt <= 4'h0;
    end
    else if (fire)
    begin
      pin <= 1'b1;
      cnt <= hold;
    end
    else if (cnt != 4'h0)
      cnt <= cnt - 4'h1;
    else
      pin <= 1'b0;
  end
endmodule : pin_source

// file: verif/tb.sv
// Self-checking bench for the capture channel
`timescale 1ns/1ps
module tb
  import capture_mode_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fire, err;
  logic ce;
  logic adc_enabled, channel_out, channel_out_drive, timer_reset, adc_start;
  logic channel_irq_flag, channel_irq, pwm_active, pin;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] tcount, a, b, cap;
  logic [15:0] exp_q[$];
  logic [9:0] pwm_duty;
  logic [3:0] hold;
  logic [3:0] cmode [7] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
  logic [6:0] cflag = 7'h7A;
  logic [6:0] cout = 7'h0A;
  logic [6:0] cdrv = 7'h1A;
  int mismatches, compares, p, trig_count, conv_count;
  integer seed;
  capture_mode_control DUT (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_pin_in(pin), .first_timer_count(tcount),
    .adc_enabled(adc_enabled), .channel_out(channel_out),
    .channel_out_drive(channel_out_drive), .timer_reset(timer_reset),
    .adc_start(adc_start), .channel_irq_flag(channel_irq_flag),
    .channel_irq(channel_irq), .pwm_active(pwm_active), .pwm_duty(pwm_duty)
  );
  pin_source partner (.pclk(pclk), .presetn(presetn), .fire(fire), .hold(hold), .pin(pin));
  // Event pulses stand one cycle, so each edge counts them once
  always @(posedge pclk)
  begin
    if (timer_reset === 1'b1)
      trig_count++;
    if (adc_start === 1'b1)
      conv_count++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Timer moves while the pin is high, so the edge used shows in the value
  task automatic pulse(input logic fall);
    a = 16'($random(seed));
    b = 16'($random(seed));
    @(posedge pclk);
    tcount <= a;
    fire <= 1'b1;
    hold <= 4'h8 + 4'($random(seed) & 7);
    @(posedge pclk);
    fire <= 1'b0;
    repeat (6) @(posedge pclk);
    tcount <= b;
    repeat (16) @(posedge pclk);
    cap = fall ? b : a;
  endtask : pulse
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    summarize();
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    seed = 32'hdd4c_7d99;
    {presetn, psel, penable, pwrite, fire, adc_enabled} = 6'h00;
    ce = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    tcount = 16'h0000;
    hold = 4'h8;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_MODE_CONTROL, 32'h0000_0000);
    chk(rd, 32'(CONTROL_RESET));
    apb(1'b1, ADDR_MODE_CONTROL, 32'h0000_00FF);
    apb(1'b0, ADDR_MODE_CONTROL, 32'h0000_0000);
    chk(rd, 32'h0000_003F);
    apb(1'b0, 8'h1C, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    apb(1'b1, ADDR_IRQ_ENABLE, 32'h0000_0001);
    for (int m = 4; m < 8; m++)
    begin
      p = (m == 6) ? 4 : (m == 7) ? 16 : 1;
      apb(1'b1, ADDR_MODE_CONTROL, 32'(m));
      pulse(1'b0);
      pulse(1'b0);
      apb(1'b1, ADDR_MODE_CONTROL, 32'h0000_0000);
      apb(1'b1, ADDR_MODE_CONTROL, 32'(m));
      apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
      for (int i = 0; i < ((p == 1) ? 2 : p); i++)
      begin
        pulse(m == 4);
        if ((i + 1) % p == 0)
          exp_q.push_back(cap);
        chk(32'(channel_irq_flag), 32'(i >= p - 1));
      end
      chk(32'(channel_irq), 32'h0000_0001);
      apb(1'b0, ADDR_CAPTURE_LOW, 32'h0000_0000);
      chk(rd, 32'(exp_q[$][7:0]));
      apb(1'b0, ADDR_CAPTURE_HIGH, 32'h0000_0000);
      chk(rd, 32'(exp_q[$][15:8]));
    end
    apb(1'b1, ADDR_COMPARE_LOW, 32'h0000_0034);
    apb(1'b1, ADDR_COMPARE_HIGH, 32'h0000_0012);
    adc_enabled <= 1'b1;
    for (int j = 0; j < 7; j++)
    begin
      tcount <= 16'h1233;
      apb(1'b1, ADDR_MODE_CONTROL, 32'h0000_0000);
      apb(1'b1, ADDR_MODE_CONTROL, 32'(cmode[j]));
      apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
      tcount <= 16'h1234;
      repeat (6) @(posedge pclk);
      chk(32'(channel_irq_flag), 32'(cflag[j]));
      chk(32'(channel_out), 32'(cout[j]));
      chk(32'(channel_out_drive), 32'(cdrv[j]));
    end
    chk(32'(trig_count), 32'h0000_0001);
    chk(32'(conv_count), 32'h0000_0001);
    apb(1'b1, ADDR_CAPTURE_LOW, 32'h0000_00AB);
    apb(1'b1, ADDR_MODE_CONTROL, 32'h0000_003C);
    repeat (2) @(posedge pclk);
    chk(32'(pwm_active), 32'h0000_0001);
    chk(32'(pwm_duty), 32'h0000_02AF);
    apb(1'b1, ADDR_MODE_CONTROL, 32'h0000_0000);
    apb(1'b1, ADDR_MODE_CONTROL, 32'(MODE_CAP_RISE));
    apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
    ce <= 1'b0;
    pulse(1'b0);
    chk(32'(channel_irq_flag), 32'h0000_0000);
    ce <= 1'b1;
    pulse(1'b0);
    chk(32'(channel_irq_flag), 32'h0000_0001);
    summarize();
  end
endmodule : tb
